// ==== sar_readout_pkg.sv ====
// Shared constants and types for the serial conversion and readout sequencer
package sar_readout_pkg;

	localparam int RESULT_W = 14;
	localparam int FILL_W = 2;
	localparam int FRAME_W = RESULT_W + FILL_W;
	localparam int SAMPLE_FALLS = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W = 3;
	localparam int IDX_W = 4;
	localparam int SYNC_W = RESULT_W + 2;

	// Falls already counted when the last sampling fall arrives
	localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_FALLS - 1);
	localparam logic [IDX_W-1:0] MSB_IDX = IDX_W'(FRAME_W - 1);
	localparam logic [IDX_W-1:0] LSB_END = IDX_W'(RESULT_W);
	localparam logic [IDX_W-1:0] LSB_BASE = IDX_W'(FILL_W);
	localparam logic [IDX_W-1:0] IDX_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [FILL_W-1:0] FILL_BITS = 2'h0;

	typedef enum logic [2:0] {
		ph_idle = 3'b000,
		ph_sample = 3'b001,
		ph_lead = 3'b010,
		ph_msb = 3'b011,
		ph_lsb = 3'b100,
		ph_done = 3'b101
	} phase_type;

endpackage : sar_readout_pkg

// ==== stream_if.sv ====
// Valid/ready word stream with a flush line, between sequencer and buffer
interface stream_if #(
	parameter int WIDTH = 16
) ();
	logic valid;
	logic ready;
	logic flush;
	logic [WIDTH-1:0] data;

	modport src (
		output valid,
		output data,
		output flush,
		input ready
	);

	modport snk (
		input valid,
		input data,
		input flush,
		output ready
	);
endinterface : stream_if

// ==== pin_sync.sv ====
// Two-stage synchroniser for pin inputs
module pin_sync #(
	parameter int WIDTH = 16
) (
	input logic ref_clk,
	input logic srst,
	input logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_type;

	sync_state_type s_r;
	sync_state_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.first = pin_in;
		s_nxt.second = s_r.first;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin_sync_out = s_r.second;

endmodule : pin_sync

// ==== stream_fifo.sv ====
// Word FIFO with valid/ready on both sides and a synchronous flush
module stream_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input logic ref_clk,
	input logic srst,
	stream_if.snk push,
	stream_if.src pop
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_state_type;

	fifo_state_type s_r;
	fifo_state_type s_nxt;
	logic do_push;
	logic do_pop;

	assign push.ready = (s_r.count != FULL_COUNT);
	assign pop.valid = (s_r.count != '0);
	assign pop.data = s_r.mem[s_r.rd];
	assign pop.flush = 1'b0;
	assign do_push = push.valid && push.ready;
	assign do_pop = pop.valid && pop.ready;

	always_comb begin
		s_nxt = s_r;
		if (push.flush) begin
			s_nxt.wr = '0;
			s_nxt.rd = '0;
			s_nxt.count = '0;
		end else begin
			if (do_push) begin
				s_nxt.mem[s_r.wr] = push.data;
				s_nxt.wr = s_r.wr + 1'b1;
			end
			if (do_pop) begin
				s_nxt.rd = s_r.rd + 1'b1;
			end
			if (do_push && !do_pop) begin
				s_nxt.count = s_r.count + 1'b1;
			end else if (do_pop && !do_push) begin
				s_nxt.count = s_r.count - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule : stream_fifo

// ==== sar_adc_serial_readout.sv ====
// Serial conversion and readout sequencer for a 14-bit differential SAR converter
// Operation
// - Every serial output bit is launched on a falling conversion clock edge.
// - Select falling starts a conversion and its serial transfer.
// - First 4.5 to 5.0 clock periods after selection sample the input.
// - At the fifth falling edge output enables and drives one low bit.
// - Next 16 periods send 14 result bits MSB first, then two zeros.
// - Further clocks with select low resend result LSB first after a zero.
// - Select rising puts the serial output into high impedance.
// - While deselected, clock edges change neither state nor output.
// - Only a high then low select starts another conversion.
// - Result is two's complement in 16 bits with two trailing zeros.
// - Power down when conversion completes and whenever deselected.
// - After completion with select low only the analog part sleeps.
// - Serial data belongs to the conversion now running, no pipeline delay.
module sar_adc_serial_readout
	import sar_readout_pkg::*;
(
	input logic ref_clk,
	input logic srst,
	input logic cs_n,
	input logic conversion_clock,
	input logic [RESULT_W-1:0] sample_code,
	output logic dout,
	output logic dout_oe,
	output logic analog_active,
	output logic digital_active
);

	typedef struct packed {
		phase_type phase;
		logic cs_last;
		logic clk_last;
		logic [CNT_W-1:0] falls;
		logic [IDX_W-1:0] idx;
		logic loaded;
		logic [FRAME_W-1:0] frame;
		logic dout;
		logic oe;
	} seq_state_type;

	seq_state_type s_r;
	seq_state_type s_nxt;

	logic [SYNC_W-1:0] pins_sync;
	logic [RESULT_W-1:0] code_s;
	logic cs_s;
	logic clk_s;
	logic cs_fell;
	logic clk_fell;
	logic [FRAME_W-1:0] cur_frame;

	stream_if #(.WIDTH(FRAME_W)) push_if ();
	stream_if #(.WIDTH(FRAME_W)) pop_if ();

	function automatic logic bit_at(
		input logic [FRAME_W-1:0] f,
		input logic [IDX_W-1:0] i
	);
		return f[i];
	endfunction : bit_at

	pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.pin_in({sample_code, cs_n, conversion_clock}),
		.pin_sync_out(pins_sync)
	);

	stream_fifo #(.WIDTH(FRAME_W), .DEPTH(FIFO_DEPTH)) u_result_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.push(push_if.snk),
		.pop(pop_if.src)
	);

	assign code_s = pins_sync[SYNC_W-1:2];
	assign cs_s = pins_sync[1];
	assign clk_s = pins_sync[0];

	// Edges seen on the synchronised pins
	assign cs_fell = !cs_s && s_r.cs_last;
	assign clk_fell = !clk_s && s_r.clk_last;

	// Freshly popped frame is used if the fall comes in the pop cycle
	assign cur_frame = s_r.loaded ? s_r.frame : pop_if.data;

	always_comb begin
		s_nxt = s_r;
		s_nxt.cs_last = cs_s;
		s_nxt.clk_last = clk_s;
		push_if.valid = 1'b0;
		push_if.data = {code_s, FILL_BITS};
		push_if.flush = (s_r.phase == ph_idle);
		pop_if.ready = 1'b0;
		if (cs_s) begin
			// Deselected: float the output and freeze on idle
			s_nxt.phase = ph_idle;
			s_nxt.oe = 1'b0;
			s_nxt.dout = 1'b0;
			s_nxt.falls = CNT_ZERO;
			s_nxt.idx = IDX_ZERO;
			s_nxt.loaded = 1'b0;
		end else if (cs_fell) begin
			s_nxt.phase = ph_sample;
			s_nxt.falls = CNT_ZERO;
			s_nxt.loaded = 1'b0;
			s_nxt.oe = 1'b0;
		end else begin
			case (s_r.phase)
				ph_sample: begin
					if (clk_fell) begin
						if (s_r.falls == SAMPLE_LAST) begin
							// Sampling window closes: hand the code to the buffer
							push_if.valid = 1'b1;
							if (push_if.ready) begin
								s_nxt.phase = ph_lead;
								s_nxt.oe = 1'b1;
								s_nxt.dout = 1'b0;
							end
						end else begin
							s_nxt.falls = s_r.falls + 1'b1;
						end
					end
				end
				ph_lead: begin
					pop_if.ready = !s_r.loaded;
					if (pop_if.valid && !s_r.loaded) begin
						s_nxt.frame = pop_if.data;
						s_nxt.loaded = 1'b1;
					end
					if (clk_fell) begin
						s_nxt.phase = ph_msb;
						s_nxt.frame = cur_frame;
						s_nxt.loaded = 1'b1;
						s_nxt.idx = MSB_IDX;
						s_nxt.dout = bit_at(cur_frame, MSB_IDX);
					end
				end
				ph_msb: begin
					if (clk_fell) begin
						if (s_r.idx == IDX_ZERO) begin
							s_nxt.phase = ph_lsb;
							s_nxt.dout = 1'b0;
						end else begin
							s_nxt.idx = s_r.idx - 1'b1;
							s_nxt.dout = bit_at(s_r.frame, s_r.idx - 1'b1);
						end
					end
				end
				ph_lsb: begin
					if (clk_fell) begin
						if (s_r.idx == LSB_END) begin
							s_nxt.phase = ph_done;
							s_nxt.dout = 1'b0;
						end else begin
							s_nxt.idx = s_r.idx + 1'b1;
							s_nxt.dout = bit_at(s_r.frame, LSB_BASE + s_r.idx);
						end
					end
				end
				ph_done: begin
					// Holds low until deselected; no restart while select stays low
					s_nxt.dout = 1'b0;
				end
				default: begin
					s_nxt.phase = ph_idle;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.dout;
	assign dout_oe = s_r.oe;
	// Comparator and array only run while a conversion is in flight
	assign analog_active = (s_r.phase == ph_sample) || (s_r.phase == ph_lead) ||
		(s_r.phase == ph_msb);
	assign digital_active = !cs_s;

	sequence conv_start_s;
		!cs_s && s_r.cs_last;
	endsequence

	sequence fifth_fall_s;
		!cs_s && s_r.phase == ph_sample && clk_fell && s_r.falls == SAMPLE_LAST && push_if.ready;
	endsequence

	sequence lead_fall_s;
		!cs_s && s_r.phase == ph_lead && clk_fell;
	endsequence

	sequence msb_end_s;
		!cs_s && s_r.phase == ph_msb && clk_fell && s_r.idx == IDX_ZERO;
	endsequence

	sequence msb_step_s;
		!cs_s && s_r.phase == ph_msb && clk_fell && s_r.idx != IDX_ZERO;
	endsequence

	sequence lsb_step_s;
		!cs_s && s_r.phase == ph_lsb && clk_fell && s_r.idx != LSB_END;
	endsequence

	sequence lsb_end_s;
		!cs_s && s_r.phase == ph_lsb && clk_fell && s_r.idx == LSB_END;
	endsequence

	start_sample_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		conv_start_s |=> s_r.phase == ph_sample && !dout_oe
	) else $error("select fall did not start sampling");

	sample_span_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		s_r.phase == ph_sample |-> s_r.falls <= SAMPLE_LAST
	) else $error("sampling ran past the fifth fall");

	sample_quiet_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(s_r.phase == ph_sample || s_r.phase == ph_idle) |-> !dout_oe
	) else $error("output driven before the fifth fall");

	lead_low_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		fifth_fall_s |=> dout_oe && !dout && s_r.phase == ph_lead
	) else $error("leading low bit missing after fifth fall");

	msb_first_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		lead_fall_s |=> s_r.phase == ph_msb && dout == s_r.frame[FRAME_W-1] && s_r.idx == MSB_IDX
	) else $error("first result bit is not the msb");

	frame_fill_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(s_r.phase == ph_msb || s_r.phase == ph_lsb) |-> s_r.frame[FILL_W-1:0] == FILL_BITS
	) else $error("frame filler bits not zero");

	fresh_code_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		fifth_fall_s |-> push_if.valid && push_if.data == {code_s, FILL_BITS}
	) else $error("frame not taken at end of sampling");

	lsb_repeat_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		msb_end_s |=> s_r.phase == ph_lsb && !dout && dout_oe && s_r.idx == IDX_ZERO
	) else $error("lsb repeat does not start with a zero");

	deselect_float_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		cs_s |=> !dout_oe && s_r.phase == ph_idle
	) else $error("output not floated while deselected");

	ignore_clock_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		cs_s && $past(cs_s) && $past(cs_s, 2) |->
			$stable(dout) && $stable(dout_oe) && s_r.phase == ph_idle
	) else $error("state moved while deselected");

	launch_edge_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		dout_oe && $past(dout_oe) && $changed(dout) |-> $past(clk_fell)
	) else $error("output bit changed without a falling clock");

	no_restart_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		s_r.phase == ph_done && !cs_s |=> s_r.phase == ph_done && !dout
	) else $error("conversion restarted without deselect");

	power_down_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		(s_r.phase == ph_done || s_r.phase == ph_lsb) && !cs_s |->
			!analog_active && digital_active
	) else $error("analog section active after conversion");

	deselect_sleep_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		cs_s |=> !analog_active
	) else $error("analog section active while deselected");

	msb_step_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		msb_step_s |=> dout == $past(bit_at(s_r.frame, s_r.idx - 1'b1)) &&
			s_r.idx == $past(s_r.idx) - 1'b1
	) else $error("msb first bit order broken");

	lsb_step_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		lsb_step_s |=> dout == $past(bit_at(s_r.frame, LSB_BASE + s_r.idx)) &&
			s_r.idx == $past(s_r.idx) + 1'b1
	) else $error("lsb first bit order broken");

	lsb_finish_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		lsb_end_s |=> s_r.phase == ph_done && !dout && dout_oe
	) else $error("lsb repeat did not end in done");

	bit_hold_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!cs_s && !clk_fell |=> $stable(dout)
	) else $error("output bit moved without a falling clock");

	lead_hold_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!cs_s && s_r.phase == ph_lead && !clk_fell |=> s_r.phase == ph_lead && !dout
	) else $error("leading low bit cut short");

	oe_steady_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		dout_oe && !cs_s |=> dout_oe
	) else $error("output enable dropped while selected");

	fall_count_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!cs_s && s_r.phase == ph_sample && clk_fell && s_r.falls != SAMPLE_LAST |=>
			s_r.phase == ph_sample && s_r.falls == $past(s_r.falls) + 1'b1
	) else $error("sampling fall not counted");

	early_push_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		s_r.phase == ph_sample && !(clk_fell && s_r.falls == SAMPLE_LAST) |-> !push_if.valid
	) else $error("code taken before sampling ended");

	push_room_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		push_if.valid |-> push_if.ready
	) else $error("result buffer full at end of sampling");

	idle_flush_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		s_r.phase == ph_idle |=> !pop_if.valid
	) else $error("stale frame left in buffer");

	lead_load_a: assert property (
		@(posedge ref_clk) disable iff (srst)
		!cs_s && s_r.phase == ph_lead && !clk_fell |=> s_r.loaded
	) else $error("fresh frame not loaded in lead phase");

endmodule : sar_adc_serial_readout

// ==== host_model.sv ====
// Host side model: drives select and conversion clock, samples serial data
module host_model #(
	parameter int HALF = 21
) (
	input wire logic ref_clk,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic analog_active,
	output logic cs_n,
	output logic conversion_clock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic db[0:63];
	logic ob[0:63];
	logic ab[0:63];
	logic lb[0:63];

	initial begin
		cs_n = 1'h1;
		conversion_clock = 1'h0;
	end

	// Half clock period, about 1.19 MHz overall
	task automatic wait_half();
		repeat (HALF) @(posedge ref_clk);
		#1;
	endtask : wait_half

	// Selected frame of n+1 falls; entry k holds what follows fall k
	task automatic frame(input int n);
		cs_n = 1'h0;
		wait_half();
		for (int k = 0; k <= n; k++) begin
			conversion_clock = 1'h1;
			db[k] = dout;
			ob[k] = dout_oe;
			ab[k] = analog_active;
			wait_half();
			lb[k] = dout;
			conversion_clock = 1'h0;
			wait_half();
		end
		cs_n = 1'h1;
	endtask : frame

	// Clocks with select high
	task automatic idle_clocks(input int n);
		for (int k = 0; k < n; k++) begin
			conversion_clock = 1'h1;
			ob[k] = dout_oe;
			ab[k] = analog_active;
			wait_half();
			conversion_clock = 1'h0;
			wait_half();
		end
	endtask : idle_clocks
endmodule : host_model

// ==== tb.sv ====
// Self-checking testbench for the serial conversion and readout sequencer
module tb
	import sar_readout_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk;
	logic srst;
	logic cs_n;
	logic conversion_clock;
	logic [RESULT_W-1:0] sample_code;
	logic dout;
	logic dout_oe;
	logic analog_active;
	logic digital_active;
	int err_total;
	int check_count;

	sar_adc_serial_readout dut (
		.ref_clk(ref_clk),
		.srst(srst),
		.cs_n(cs_n),
		.conversion_clock(conversion_clock),
		.sample_code(sample_code),
		.dout(dout),
		.dout_oe(dout_oe),
		.analog_active(analog_active),
		.digital_active(digital_active)
	);

	host_model host (
		.ref_clk(ref_clk),
		.dout(dout),
		.dout_oe(dout_oe),
		.analog_active(analog_active),
		.cs_n(cs_n),
		.conversion_clock(conversion_clock)
	);

	initial ref_clk = 1'h0;
	always #10 ref_clk = ~ref_clk;

	task automatic chk(input logic exp, input logic got, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s exp %b got %b", $time, what, exp, got);
		end
	endtask : chk

	task automatic chk_word(input logic [FRAME_W-1:0] exp, input logic [FRAME_W-1:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: word exp %h got %h", $time, exp, got);
		end
	endtask : chk_word

	// Expected serial bit after fall k
	function automatic logic exp_bit(input logic [RESULT_W-1:0] c, input int k);
		logic [FRAME_W-1:0] f;
		f = {c, FILL_BITS};
		if (k >= 6 && k <= 21) return f[21 - k];
		if (k >= 23 && k <= 36) return c[k - 23];
		return 1'h0;
	endfunction : exp_bit

	task automatic run_frame(input logic [RESULT_W-1:0] c, input int n);
		@(posedge ref_clk);
		#1;
		sample_code = c;
		host.frame(n);
		for (int k = 0; k <= n; k++) begin
			chk(k >= 5, host.ob[k], "enable");
			chk(k <= 21, host.ab[k], "analog");
			if (k >= 5) begin
				chk(exp_bit(c, k), host.db[k], "data");
				chk(exp_bit(c, k), host.lb[k], "held");
			end
		end
		repeat (6) @(posedge ref_clk);
		#1;
		chk(1'h0, dout_oe, "tristate");
		chk(1'h0, digital_active, "digital");
		chk(1'h0, analog_active, "analog idle");
	endtask : run_frame

	task automatic t_full();
		run_frame(14'h2a5c, 45);
		$display("test full done");
	endtask : t_full

	task automatic t_codes();
		logic [RESULT_W-1:0] codes[5] = '{14'h1fff, 14'h0000, 14'h3fff, 14'h2000, 14'h1555};
		logic [FRAME_W-1:0] words[5] = '{16'h7ffc, 16'h0000, 16'hfffc, 16'h8000, 16'h5554};
		logic [FRAME_W-1:0] w;
		for (int i = 0; i < 5; i++) begin
			run_frame(codes[i], 22);
			for (int j = 0; j < FRAME_W; j++) begin
				w[15 - j] = host.db[6 + j];
			end
			chk_word(words[i], w);
		end
		$display("test codes done");
	endtask : t_codes

	task automatic t_abort();
		run_frame(14'h0f0f, 12);
		run_frame(14'h3001, 22);
		$display("test abort done");
	endtask : t_abort

	task automatic t_deselected();
		host.idle_clocks(8);
		for (int k = 0; k < 8; k++) begin
			chk(1'h0, host.ob[k], "idle enable");
			chk(1'h0, host.ab[k], "idle analog");
		end
		run_frame(14'h0001, 22);
		$display("test deselected done");
	endtask : t_deselected

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	// Watchdog well beyond the expected run of about 200 us
	initial begin
		#500000;
		err_total++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		test_done();
	end

	initial begin
		srst = 1'h1;
		sample_code = 14'h0000;
		err_total = 0;
		check_count = 0;
		repeat (5) @(posedge ref_clk);
		#1;
		srst = 1'h0;
		repeat (3) @(posedge ref_clk);
		t_full();
		t_codes();
		t_abort();
		t_deselected();
		test_done();
	end
endmodule : tb
